// ===== fid_pkg.sv
package fid_pkg;
    localparam int ADDR_W = 16;
    localparam int CMD_AW = 12;
    localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
    localparam logic [11:0] UNLOCK2_ADDR = 12'hAAA;
    localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
    localparam logic [7:0] UNLOCK2_DATA = 8'h55;
    localparam logic [7:0] CMD_ID = 8'h90;
    localparam logic [7:0] CMD_PROG = 8'hA0;
    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_SECTOR = 8'h30;
    localparam logic [7:0] CMD_BULK = 8'h10;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] CMD_BYPASS = 8'h20;
    localparam logic [7:0] CMD_BYP_EXIT = 8'h00;
    localparam logic [11:0] ID_OFFSET = 12'h001;
    localparam logic [11:0] PROT_OFFSET = 12'h002;
    localparam logic [7:0] PROT_YES = 8'h01;
    localparam logic [7:0] PROT_NO = 8'h00;
    localparam int CLK_MHZ = 100;
    localparam int SECTOR_WINDOW_US = 80;
    localparam int SECTOR_WINDOW_CYC = SECTOR_WINDOW_US * CLK_MHZ;
    localparam int TIMEOUT_CYC = 1000;
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int ERROR_BIT = 5;
    typedef enum logic [3:0] {
        FID_IDLE = 4'h0,
        FID_U1 = 4'h1,
        FID_U2 = 4'h2,
        FID_ER3 = 4'h3,
        FID_ER4 = 4'h4,
        FID_ER5 = 4'h5,
        FID_PROG = 4'h6,
        FID_IDRD = 4'h7,
        FID_BYP = 4'h8,
        FID_BYP_PROG = 4'h9,
        FID_BYP_EXIT = 4'hA,
        FID_SECQ = 4'hB
    } fid_state_t;
    typedef enum logic [1:0] {
        FID_OP_NONE = 2'h0,
        FID_OP_PROG = 2'h1,
        FID_OP_SECT = 2'h2,
        FID_OP_BULK = 2'h3
    } fid_op_t;
endpackage

// ===== fid_bus_if.sv
`timescale 1ns/100ps
interface fid_bus_if;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic wr_n;
    logic rd_n;
    logic [7:0] main_sector_selects;
    logic [3:0] boot_sector_selects;
    modport dev (
        input addr, wdata, wr_n, rd_n, main_sector_selects,
        input boot_sector_selects,
        output rdata
    );
    modport host (
        output addr, wdata, wr_n, rd_n, main_sector_selects,
        output boot_sector_selects,
        input rdata
    );
endinterface

// ===== fid_device.sv
`timescale 1ns/100ps
module fid_device #(
    parameter int TIMEOUT = fid_pkg::TIMEOUT_CYC,
    parameter int SECT_WIN = fid_pkg::SECTOR_WINDOW_CYC,
    parameter bit BYPASS_EN = 1'b1,
    parameter logic [7:0] MAIN_ID = 8'h5A // Arbitrary value
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Microcontroller bus
    fid_bus_if.dev bus,
    // Array side
    input wire logic [7:0] array_rdata_i,
    input wire logic [11:0] sector_protect_i,
    input wire logic op_done_i,
    input wire logic op_error_i,
    output logic op_start_o,
    output logic [1:0] op_kind_o,
    output logic op_main_o,
    output logic [15:0] op_addr_o,
    output logic [7:0] op_data_o,
    output logic [11:0] op_sectors_o,
    output logic erase_suspend_o,
    output logic busy_o
);
    logic [1:0] wr_s_r, rd_s_r;
    logic wr_d_r, rd_d_r;
    logic [15:0] a_s1_r, a_s2_r;
    logic [7:0] d_s1_r, d_s2_r;
    logic [11:0] sel_s1_r, sel_s2_r;
    logic [15:0] lat_addr_r;
    logic [11:0] lat_sel_r;
    fid_pkg::fid_state_t st_r, st_nxt;
    logic [31:0] tmo_r, win_r;
    logic bypass_r, susp_r, erasing_r, err_r, tog_r;
    always_ff @(posedge clk_i) begin
        wr_s_r <= {wr_s_r[0], bus.wr_n};
        rd_s_r <= {rd_s_r[0], bus.rd_n};
        a_s1_r <= bus.addr;
        a_s2_r <= a_s1_r;
        d_s1_r <= bus.wdata;
        d_s2_r <= d_s1_r;
        sel_s1_r <= {bus.boot_sector_selects, bus.main_sector_selects};
        sel_s2_r <= sel_s1_r;
        wr_d_r <= wr_s_r[1];
        rd_d_r <= rd_s_r[1];
    end
    wire wr_fall = wr_d_r & ~wr_s_r[1];
    wire wr_rise = ~wr_d_r & wr_s_r[1];
    wire rd_fall = rd_d_r & ~rd_s_r[1];
    wire [11:0] a12 = lat_addr_r[11:0];
    wire [7:0] wd = d_s2_r;
    wire any_sel = |lat_sel_r;
    wire is_main = |lat_sel_r[7:0];
    wire at555 = a12 == fid_pkg::UNLOCK1_ADDR;
    wire wstb = wr_rise & any_sel;
    wire timed_out = st_r != fid_pkg::FID_IDLE && st_r != fid_pkg::FID_BYP
        && st_r != fid_pkg::FID_IDRD && st_r != fid_pkg::FID_SECQ
        && tmo_r >= 32'(TIMEOUT);
    wire win_end = st_r == fid_pkg::FID_SECQ && win_r >= 32'(SECT_WIN);
    logic go;
    fid_pkg::fid_op_t kind;
    always_comb begin
        st_nxt = st_r;
        go = 1'b0;
        kind = fid_pkg::FID_OP_NONE;
        if (wstb) begin
            st_nxt = bypass_r ? fid_pkg::FID_BYP : fid_pkg::FID_IDLE;
            case (st_r)
                fid_pkg::FID_IDLE, fid_pkg::FID_IDRD: begin
                    if (wd == fid_pkg::UNLOCK1_DATA && at555 && !busy_o)
                        st_nxt = fid_pkg::FID_U1;
                    else if (wd != fid_pkg::CMD_RESET
                        && st_r == fid_pkg::FID_IDRD)
                        st_nxt = fid_pkg::FID_IDRD;
                end
                fid_pkg::FID_U1: begin
                    if (wd == fid_pkg::UNLOCK2_DATA
                        && a12 == fid_pkg::UNLOCK2_ADDR)
                        st_nxt = fid_pkg::FID_U2;
                end
                fid_pkg::FID_U2: begin
                    if (at555 && wd == fid_pkg::CMD_ID && is_main)
                        st_nxt = fid_pkg::FID_IDRD;
                    else if (at555 && wd == fid_pkg::CMD_PROG)
                        st_nxt = fid_pkg::FID_PROG;
                    else if (at555 && wd == fid_pkg::CMD_ERASE && !susp_r)
                        st_nxt = fid_pkg::FID_ER3;
                    else if (at555 && wd == fid_pkg::CMD_BYPASS && BYPASS_EN)
                        st_nxt = fid_pkg::FID_BYP;
                end
                fid_pkg::FID_ER3: begin
                    if (at555 && wd == fid_pkg::UNLOCK1_DATA)
                        st_nxt = fid_pkg::FID_ER4;
                end
                fid_pkg::FID_ER4: begin
                    if (a12 == fid_pkg::UNLOCK2_ADDR
                        && wd == fid_pkg::UNLOCK2_DATA)
                        st_nxt = fid_pkg::FID_ER5;
                end
                fid_pkg::FID_ER5: begin
                    if (wd == fid_pkg::CMD_SECTOR)
                        st_nxt = fid_pkg::FID_SECQ;
                    else if (at555 && wd == fid_pkg::CMD_BULK) begin
                        go = 1'b1;
                        kind = fid_pkg::FID_OP_BULK;
                    end
                end
                fid_pkg::FID_SECQ: begin
                    if (wd == fid_pkg::CMD_SECTOR)
                        st_nxt = fid_pkg::FID_SECQ;
                end
                fid_pkg::FID_PROG, fid_pkg::FID_BYP_PROG: begin
                    go = 1'b1;
                    kind = fid_pkg::FID_OP_PROG;
                end
                fid_pkg::FID_BYP: begin
                    if (wd == fid_pkg::CMD_PROG)
                        st_nxt = fid_pkg::FID_BYP_PROG;
                    else if (wd == fid_pkg::CMD_ID)
                        st_nxt = fid_pkg::FID_BYP_EXIT;
                end
                fid_pkg::FID_BYP_EXIT: begin
                    if (wd == fid_pkg::CMD_BYP_EXIT)
                        st_nxt = fid_pkg::FID_IDLE;
                end
                default: st_nxt = fid_pkg::FID_IDLE;
            endcase
            if (wd == fid_pkg::CMD_RESET && !bypass_r)
                st_nxt = fid_pkg::FID_IDLE;
        end else if (timed_out) begin
            st_nxt = bypass_r ? fid_pkg::FID_BYP : fid_pkg::FID_IDLE;
        end else if (win_end) begin
            st_nxt = fid_pkg::FID_IDLE;
            go = 1'b1;
            kind = fid_pkg::FID_OP_SECT;
        end
    end
    wire sus_cmd = wstb && wd == fid_pkg::CMD_SUSPEND
        && erasing_r && !susp_r;
    wire res_cmd = wstb && wd == fid_pkg::CMD_SECTOR && susp_r
        && st_r != fid_pkg::FID_ER5
        && st_r != fid_pkg::FID_SECQ;
    always_ff @(posedge clk_i) begin
        if (wr_fall) begin
            lat_addr_r <= a_s2_r;
            lat_sel_r <= sel_s2_r;
        end
        if (reset_i) begin
            st_r <= fid_pkg::FID_IDLE;
            tmo_r <= '0;
            win_r <= '0;
            bypass_r <= 1'b0;
            susp_r <= 1'b0;
            erasing_r <= 1'b0;
            err_r <= 1'b0;
            tog_r <= 1'b0;
            op_start_o <= 1'b0;
            op_kind_o <= '0;
            op_main_o <= 1'b0;
            op_addr_o <= '0;
            op_data_o <= '0;
            op_sectors_o <= '0;
            busy_o <= 1'b0;
            bus.rdata <= '0;
            lat_addr_r <= '0;
            lat_sel_r <= '0;
        end else begin
            st_r <= (sus_cmd || res_cmd) ? st_r : st_nxt;
            tmo_r <= wstb ? '0 : tmo_r + 32'd1;
            win_r <= (wstb && wd == fid_pkg::CMD_SECTOR) ? '0
                : win_r + 32'd1;
            if (wstb && st_r == fid_pkg::FID_U2 && at555
                && wd == fid_pkg::CMD_BYPASS && BYPASS_EN)
                bypass_r <= 1'b1;
            else if (wstb && st_r == fid_pkg::FID_BYP_EXIT
                && wd == fid_pkg::CMD_BYP_EXIT)
                bypass_r <= 1'b0;
            if (sus_cmd)
                susp_r <= 1'b1;
            else if (res_cmd)
                susp_r <= 1'b0;
            op_start_o <= go && !sus_cmd && !res_cmd;
            if (go) begin
                op_kind_o <= kind;
                op_main_o <= is_main;
                op_addr_o <= lat_addr_r;
                op_data_o <= wd;
                busy_o <= 1'b1;
                erasing_r <= kind != fid_pkg::FID_OP_PROG;
            end else if (op_done_i) begin
                busy_o <= 1'b0;
                erasing_r <= 1'b0;
            end
            if (wstb && st_r == fid_pkg::FID_ER5)
                op_sectors_o <= lat_sel_r;
            else if (wstb && st_r == fid_pkg::FID_SECQ
                && wd == fid_pkg::CMD_SECTOR)
                op_sectors_o <= op_sectors_o | lat_sel_r;
            if (op_error_i)
                err_r <= 1'b1;
            else if (wstb && wd == fid_pkg::CMD_RESET)
                err_r <= 1'b0;
            if (rd_fall) begin
                tog_r <= busy_o & ~susp_r ? ~tog_r : tog_r;
                if (busy_o && !susp_r) begin
                    bus.rdata <= 8'h00;
                    bus.rdata[fid_pkg::POLL_BIT] <= erasing_r ? 1'b0
                        : ~op_data_o[fid_pkg::POLL_BIT];
                    bus.rdata[fid_pkg::TOGGLE_BIT] <= ~tog_r;
                    bus.rdata[fid_pkg::ERROR_BIT] <= err_r;
                end else if (st_r == fid_pkg::FID_IDRD
                    && a_s2_r[11:0] == fid_pkg::ID_OFFSET)
                    bus.rdata <= MAIN_ID;
                else if (st_r == fid_pkg::FID_IDRD
                    && a_s2_r[11:0] == fid_pkg::PROT_OFFSET)
                    bus.rdata <= |(sel_s2_r & sector_protect_i)
                        ? fid_pkg::PROT_YES : fid_pkg::PROT_NO;
                else
                    bus.rdata <= array_rdata_i;
            end
        end
    end
    assign erase_suspend_o = susp_r;
endmodule

// ===== fid_host.sv
`timescale 1ns/100ps
module fid_host #(
    parameter int HALF = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // User request
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic [15:0] req_addr_i,
    input wire logic [7:0] req_data_i,
    input wire logic [7:0] req_main_sel_i,
    input wire logic [3:0] req_boot_sel_i,
    output logic ready_o,
    output logic done_o,
    output logic [7:0] rdata_o,
    // Flash bus
    fid_bus_if.host bus
);
    logic [7:0] cnt_r;
    logic [1:0] ph_r;
    logic wr_r;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ph_r <= 2'h0;
            cnt_r <= '0;
            ready_o <= 1'b1;
            done_o <= 1'b0;
            rdata_o <= '0;
            wr_r <= 1'b0;
            bus.wr_n <= 1'b1;
            bus.rd_n <= 1'b1;
            bus.addr <= '0;
            bus.wdata <= '0;
            bus.main_sector_selects <= '0;
            bus.boot_sector_selects <= '0;
        end else begin
            done_o <= 1'b0;
            case (ph_r)
                2'h0: begin
                    if (req_i) begin
                        ready_o <= 1'b0;
                        wr_r <= req_write_i;
                        bus.addr <= req_addr_i;
                        bus.wdata <= req_data_i;
                        bus.main_sector_selects <= req_main_sel_i;
                        bus.boot_sector_selects <= req_boot_sel_i;
                        cnt_r <= '0;
                        ph_r <= 2'h1;
                    end
                end
                2'h1: begin
                    bus.wr_n <= ~wr_r;
                    bus.rd_n <= wr_r;
                    cnt_r <= cnt_r + 8'h01;
                    if (cnt_r == 8'(HALF)) begin
                        cnt_r <= '0;
                        ph_r <= 2'h2;
                    end
                end
                2'h2: begin
                    bus.wr_n <= 1'b1;
                    bus.rd_n <= 1'b1;
                    if (!wr_r)
                        rdata_o <= bus.rdata;
                    cnt_r <= cnt_r + 8'h01;
                    if (cnt_r == 8'(HALF)) begin
                        bus.main_sector_selects <= '0;
                        bus.boot_sector_selects <= '0;
                        ph_r <= 2'h0;
                        ready_o <= 1'b1;
                        done_o <= 1'b1;
                    end
                end
                default: ph_r <= 2'h0;
            endcase
        end
    end
endmodule

// ===== fid_props.sv
`timescale 1ns/100ps
module fid_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Bus
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic [7:0] main_sector_selects,
    input wire logic [3:0] boot_sector_selects
);
    wire logic sel_any;
    assign sel_any = (main_sector_selects != 8'h00)
        || (boot_sector_selects != 4'h0);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    a_idle_in_reset: assert property (disable iff (1'b0)
        reset_i && $past(reset_i) |-> wr_n && rd_n && !sel_any)
        else $error("bus not idle in reset");
    a_addr_at_fall: assert property (
        $fell(wr_n) |-> $stable(addr) && sel_any)
        else $error("address moved at strobe fall");
    a_write_low_len: assert property (
        $fell(wr_n) |-> (!wr_n) [*5] ##1 wr_n)
        else $error("write strobe length wrong");
    a_addr_held_low: assert property (
        !wr_n && $past(!wr_n) |-> $stable(addr))
        else $error("address moved during strobe");
    a_data_at_rise: assert property (
        $rose(wr_n) |-> $stable(wdata) && $stable(addr))
        else $error("data moved at strobe rise");
    a_sel_in_write: assert property (
        !wr_n |-> sel_any)
        else $error("write without sector select");
    a_read_selected: assert property (
        !rd_n |-> sel_any && wr_n)
        else $error("read without select or with write");
    a_read_low_len: assert property (
        $fell(rd_n) |-> (!rd_n) [*5] ##1 rd_n)
        else $error("read strobe length wrong");
    a_sel_released: assert property (
        $rose(wr_n) |-> ##[1:12] !sel_any)
        else $error("selects not released");
    a_rdata_held: assert property (
        $rose(rd_n) |-> $stable(rdata) [*4])
        else $error("read data moved before capture");
endmodule

// ===== tb.sv
`timescale 1ns/100ps
module tb;
    localparam logic [7:0] ID_VAL = 8'h3C; // Arbitrary value
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic req_i = 1'b0;
    logic req_write_i = 1'b0;
    logic [15:0] req_addr_i = 16'h0000;
    logic [7:0] req_data_i = 8'h00;
    logic [7:0] ms = 8'h01;
    logic [3:0] bs = 4'h0;
    logic [7:0] array_rdata_i = 8'hC3;
    logic [11:0] sector_protect_i = 12'h004;
    logic op_done_i = 1'b0;
    logic op_error_i = 1'b0;
    logic ready_o, done_o, op_start_o, op_main_o, erase_suspend_o, busy_o;
    logic [7:0] rdata_o;
    logic [7:0] op_data_o;
    logic [1:0] op_kind_o;
    logic [15:0] op_addr_o;
    logic [11:0] op_sectors_o;
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;
    int starts = 0;
    int exp_starts = 0;
    fid_bus_if fid_bus_if_inst ();
    fid_device #(.TIMEOUT(60), .SECT_WIN(30), .BYPASS_EN(1'b1),
        .MAIN_ID(ID_VAL)) fid_device_inst (.clk_i(clk_i),
        .reset_i(reset_i), .bus(fid_bus_if_inst.dev),
        .array_rdata_i(array_rdata_i), .sector_protect_i(sector_protect_i),
        .op_done_i(op_done_i), .op_error_i(op_error_i),
        .op_start_o(op_start_o),
        .op_kind_o(op_kind_o), .op_main_o(op_main_o),
        .op_addr_o(op_addr_o), .op_data_o(op_data_o),
        .op_sectors_o(op_sectors_o), .erase_suspend_o(erase_suspend_o),
        .busy_o(busy_o));
    fid_host #(.HALF(4)) fid_host_inst (.clk_i(clk_i), .reset_i(reset_i),
        .req_i(req_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
        .req_data_i(req_data_i), .req_main_sel_i(ms), .req_boot_sel_i(bs),
        .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o),
        .bus(fid_bus_if_inst.host));
    fid_props fid_props_inst (.clk_i(clk_i), .reset_i(reset_i),
        .addr(fid_bus_if_inst.addr), .wdata(fid_bus_if_inst.wdata),
        .rdata(fid_bus_if_inst.rdata), .wr_n(fid_bus_if_inst.wr_n),
        .rd_n(fid_bus_if_inst.rd_n),
        .main_sector_selects(fid_bus_if_inst.main_sector_selects),
        .boot_sector_selects(fid_bus_if_inst.boot_sector_selects));
    always #5 clk_i = ~clk_i;
    task automatic end_of_test();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Counts launches and cuts a hang short
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (op_start_o === 1'b1) begin
            starts <= starts + 1;
        end
        if (cycles == 20000) begin
            $display("unexpected %0t timeout", $time);
            error_cnt++;
            end_of_test();
        end
    end
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("unexpected %0t %s", $time, msg);
        end
    endtask
    task automatic cyc(input logic w, input logic [15:0] a,
        input logic [7:0] d);
        int n;
        n = 0;
        while (ready_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        req_i <= 1'b1;
        req_write_i <= w;
        req_addr_i <= a;
        req_data_i <= d;
        @(posedge clk_i);
        req_i <= 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        chk(n < 50, "bus cycle hung");
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cyc(1'b1, a, d);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        cyc(1'b0, a, 8'h00);
        chk(rdata_o === e, "read data");
    endtask
    task automatic unlock();
        wr(16'hF555, 8'hAA);
        wr(16'h3AAA, 8'h55);
    endtask
    task automatic erase_pre();
        unlock();
        wr(16'h8555, 8'h80);
        unlock();
    endtask
    task automatic op(input logic want, input logic [1:0] k,
        input logic m);
        int n;
        n = 0;
        exp_starts = exp_starts + want;
        while (n < 80 && !(want && starts == exp_starts)) begin
            @(posedge clk_i);
            n++;
        end
        chk(starts == exp_starts, "launch count");
        if (want) begin
            chk(op_kind_o === k && op_main_o === m, "op kind");
        end
    endtask
    task automatic fin();
        op_done_i <= 1'b1;
        @(posedge clk_i);
        op_done_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic settle();
        repeat (6) @(posedge clk_i);
    endtask
    task automatic t_program();
        logic [7:0] s;
        ms <= 8'h01;
        bs <= 4'h0;
        unlock();
        wr(16'hF555, 8'hA0);
        wr(16'h2468, 8'h96);
        op(1'b1, 2'h1, 1'b1);
        chk(op_addr_o === 16'h2468 && op_data_o === 8'h96, "prog");
        cyc(1'b0, 16'h2468, 8'h00);
        s = rdata_o;
        cyc(1'b0, 16'h2468, 8'h00);
        chk(s[7] === 1'b0 && rdata_o[7] === 1'b0, "poll bit");
        chk((s[6] ^ rdata_o[6]) === 1'b1, "toggle bit");
        fin();
        rd(16'h2468, 8'hC3);
    endtask
    task automatic t_id();
        ms <= 8'h04;
        unlock();
        wr(16'h1555, 8'h90);
        rd(16'hE001, ID_VAL);
        rd(16'h0002, 8'h01);
        ms <= 8'h08;
        rd(16'h0002, 8'h00);
        wr(16'h0ABC, 8'hF0);
        array_rdata_i <= 8'h5E;
        rd(16'h0002, 8'h5E);
        ms <= 8'h00;
        bs <= 4'h1;
        unlock();
        wr(16'h0555, 8'h90);
        rd(16'h0001, 8'h5E);
        bs <= 4'h0;
    endtask
    task automatic t_bad();
        ms <= 8'h01;
        wr(16'h0555, 8'hAA);
        wr(16'h0555, 8'h55);
        wr(16'h0555, 8'hA0);
        wr(16'h0100, 8'h12);
        op(1'b0, 2'h0, 1'b0);
        unlock();
        repeat (70) @(posedge clk_i);
        wr(16'h0555, 8'hA0);
        wr(16'h0100, 8'h12);
        op(1'b0, 2'h0, 1'b0);
        rd(16'h0100, 8'h5E);
    endtask
    task automatic t_erase();
        ms <= 8'h10;
        erase_pre();
        wr(16'h4000, 8'h30);
        ms <= 8'h20;
        wr(16'h6000, 8'h30);
        op(1'b1, 2'h2, 1'b1);
        chk(op_sectors_o === 12'h030 && busy_o === 1'b1, "sectors");
        wr(16'h0123, 8'hB0);
        settle();
        chk(erase_suspend_o === 1'b1, "suspend");
        wr(16'h0777, 8'h30);
        settle();
        chk(erase_suspend_o === 1'b0, "resume");
        fin();
        chk(busy_o === 1'b0, "busy left");
        wr(16'h0123, 8'hB0);
        settle();
        chk(erase_suspend_o === 1'b0, "idle suspend");
    endtask
    task automatic t_bulk();
        ms <= 8'h00;
        bs <= 4'h2;
        erase_pre();
        wr(16'h0555, 8'h10);
        op(1'b1, 2'h3, 1'b0);
        op_error_i <= 1'b1;
        @(posedge clk_i);
        op_error_i <= 1'b0;
        cyc(1'b0, 16'h0000, 8'h00);
        chk(rdata_o[7] === 1'b0 && rdata_o[5] === 1'b1, "error bit");
        wr(16'h0ABC, 8'hF0);
        cyc(1'b0, 16'h0000, 8'h00);
        chk(rdata_o[5] === 1'b0, "error cleared");
        fin();
    endtask
    task automatic t_bypass();
        ms <= 8'h01;
        bs <= 4'h0;
        unlock();
        wr(16'h0555, 8'h20);
        wr(16'h0777, 8'hA0);
        wr(16'h1234, 8'h5A);
        op(1'b1, 2'h1, 1'b1);
        chk(op_addr_o === 16'h1234 && op_data_o === 8'h5A, "bypass");
        fin();
        wr(16'h0321, 8'h90);
        wr(16'h0654, 8'h00);
        wr(16'h0777, 8'hA0);
        wr(16'h1234, 8'h5A);
        op(1'b0, 2'h0, 1'b0);
    endtask
    task automatic t_reset();
        unlock();
        wr(16'h0555, 8'h20);
        reset_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        wr(16'h0777, 8'hA0);
        wr(16'h0777, 8'hA0);
        wr(16'h1234, 8'h5A);
        op(1'b0, 2'h0, 1'b0);
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        t_program();
        t_id();
        t_bad();
        t_erase();
        t_bulk();
        t_bypass();
        t_reset();
        end_of_test();
    end
endmodule
